// ### rtl/fpp_core.sv
`timescale 1ns/1ns
`include "fpp_defs.svh"
// Summary of operation
// - system clock split into four sequential non-overlapping phase clocks
// - one pass through four phases is one instruction cycle
// - fetch happens in first phase, pc advances at end of that phase
// - decode and execute occupy phases two, three and four
// - next fetch overlaps current execute, one instruction per cycle
// - pc-altering instructions take one extra cycle, two in total
// - branch: first cycle gets target, second cycle performs branch
// - an 8-bit alu handles nearly all operations
// - operands and results move through accumulator and alu only
// - pc low byte mapped in data memory as a store target, direct and indirect access
// - met skip condition discards prefetched word, dummy cycle follows
// - store (direct or indirect) to pc low byte jumps inside 256 page, one dummy cycle
module fpp_core
  import fpp_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [`FPP_IW_W-1:0]  imem_data_i,
  input  wire logic [7:0]            dmem_rdata_i,
  output logic      [`FPP_PC_W-1:0]  imem_addr_o,
  output logic                       imem_rd_o,
  output fpp_dmem_req_t              dmem_o,
  output logic      [3:0]            phase_clocks_o,
  output logic                       instr_cycle_o,
  output logic                       dummy_cycle_o,
  output logic      [7:0]            acc_o
);
  fpp_phase_t              phase_q;
  logic [`FPP_PC_W-1:0]    pc_q;
  logic [`FPP_IW_W-1:0]    ir_q;
  logic                    ir_valid_q;
  logic [`FPP_IW_W-1:0]    exec_q;
  logic                    exec_valid_q;
  logic [7:0]              acc_q;
  logic [7:0]              mp_q;
  logic [7:0]              mem_q;
  logic                    flush_q;
  logic                    flush_d;
  logic                    load_pc;
  logic [`FPP_PC_W-1:0]    tgt;
  logic [`FPP_PC_W-1:0]    stack_q [`FPP_STACK_D];
  logic [1:0]              sp_q;
  fpp_alu_res_t            alu;
  fpp_aluop_t              aop;
  logic [3:0]              opc;
  logic [7:0]              arg;
  logic                    is_ind;
  logic [7:0]              eff_addr;

  function automatic logic is_branch(input logic [3:0] o);
    is_branch = (o == `FPP_OP_JMP) || (o == `FPP_OP_CALL) || (o == `FPP_OP_RET);
  endfunction

  assign opc      = exec_q[15:12];
  assign arg      = exec_q[7:0];
  assign aop      = fpp_aluop_t'(exec_q[10:8]);
  assign is_ind   = (opc == `FPP_OP_LDIND) || (opc == `FPP_OP_STIND);
  // indirect through pointer, direct through operand field
  assign eff_addr = is_ind ? mp_q : arg;

  // phase sequencer
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      phase_q <= PH_T1;
    else
      phase_q <= fpp_phase_t'(phase_q + 2'h1);
  end

  always_comb
  begin
    phase_clocks_o = 4'h0;
    phase_clocks_o[phase_q] = 1'b1;
  end

  assign instr_cycle_o = (phase_q == PH_T4);

  fpp_alu u_alu
  (
    .a_i   (acc_q),
    .b_i   (opc == `FPP_OP_LDI ? arg : mem_q),
    .op_i  (aop),
    .res_o (alu)
  );

  // redirect decision, valid at T4
  always_comb
  begin
    load_pc = 1'b0;
    tgt     = pc_q;
    flush_d = 1'b0;
    if (exec_valid_q)
    begin
      case (opc)
        `FPP_OP_JMP, `FPP_OP_CALL:
        begin
          load_pc = 1'b1;
          tgt     = exec_q[`FPP_PC_W-1:0];
        end
        `FPP_OP_RET:
        begin
          load_pc = 1'b1;
          tgt     = stack_q[sp_q - 2'h1];
        end
        `FPP_OP_SZ:  flush_d = alu.zero;
        `FPP_OP_SNZ: flush_d = !alu.zero;
        `FPP_OP_ST, `FPP_OP_STIND:
          if (eff_addr == `FPP_PCL_ADDR)
          begin
            load_pc = 1'b1;
            tgt     = {pc_q[`FPP_PC_W-1:8], acc_q};
          end
        default: load_pc = 1'b0;
      endcase
    end
  end

  // fetch in T1 at advanced pc; branch target loaded at T4
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      pc_q <= `FPP_PC_RESET;
    else if (phase_q == PH_T4 && load_pc)
      pc_q <= tgt;
    else if (phase_q == PH_T1)
      pc_q <= pc_q + 11'h001;
  end

  assign imem_addr_o = pc_q;
  assign imem_rd_o   = (phase_q == PH_T1);

  // prefetch register, loaded in T1 while current word executes
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ir_q       <= `FPP_NOP_WORD;
      ir_valid_q <= 1'b0;
    end
    else if (phase_q == PH_T1)
    begin
      ir_q       <= imem_data_i;
      ir_valid_q <= 1'b1;
    end
    else if (phase_q == PH_T4 && (load_pc || flush_d))
      ir_valid_q <= 1'b0;
  end

  // execute slot; a branch spends its second cycle as a dummy
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      exec_q       <= `FPP_NOP_WORD;
      exec_valid_q <= 1'b0;
      flush_q      <= 1'b0;
    end
    else if (phase_q == PH_T4)
    begin
      exec_q       <= (ir_valid_q && !load_pc && !flush_d) ? ir_q : `FPP_NOP_WORD;
      exec_valid_q <= ir_valid_q && !load_pc && !flush_d;
      flush_q      <= load_pc || flush_d;
    end
  end

  assign dummy_cycle_o = flush_q;

  // data memory read in T2, operand captured in T3
  always_comb
  begin
    dmem_o       = '0;
    dmem_o.addr  = eff_addr;
    dmem_o.wdata = (opc == `FPP_OP_ALUM) ? alu.res : acc_q;
    if (exec_valid_q)
    begin
      dmem_o.rd = (phase_q == PH_T2);
      dmem_o.wr = (phase_q == PH_T4) && ((opc == `FPP_OP_ST) || (opc == `FPP_OP_STIND) || (opc == `FPP_OP_ALUM));
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      mem_q <= 8'h00;
    else if (phase_q == PH_T3)
      mem_q <= dmem_rdata_i;
  end

  // accumulator written in T4 only from the alu, memory or the immediate operand
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      acc_q <= 8'h00;
    else if (phase_q == PH_T4 && exec_valid_q)
    begin
      case (opc)
        `FPP_OP_ALU, `FPP_OP_LDI: acc_q <= (opc == `FPP_OP_LDI) ? arg : alu.res;
        `FPP_OP_LDM, `FPP_OP_LDIND: acc_q <= mem_q;
        default: acc_q <= acc_q;
      endcase
    end
  end

  assign acc_o = acc_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      mp_q <= 8'h00;
    else if (phase_q == PH_T4 && exec_valid_q && opc == `FPP_OP_SETMP)
      mp_q <= arg;
  end

  // return stack
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      sp_q <= 2'h0;
    else if (phase_q == PH_T4 && exec_valid_q && opc == `FPP_OP_CALL)
    begin
      // pc already points past the discarded prefetch, return to that word
      stack_q[sp_q] <= pc_q - 11'h001;
      sp_q          <= sp_q + 2'h1;
    end
    else if (phase_q == PH_T4 && exec_valid_q && opc == `FPP_OP_RET)
      sp_q <= sp_q - 2'h1;
  end

  sequence t4_redirect_s;
    phase_q == PH_T4 && load_pc;
  endsequence

  sequence dummy_slot_s;
    !exec_valid_q [*4] ##1 exec_valid_q;
  endsequence

  phase_wrap_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    phase_q == PH_T4 |=> phase_q == PH_T1)
    else $error("phase did not wrap to first");
  one_hot_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $onehot(phase_clocks_o))
    else $error("phase clocks overlap");
  fetch_t1_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    imem_rd_o |=> pc_q == $past(pc_q) + 11'h001)
    else $error("pc not advanced at fetch");
  dmem_phase_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (dmem_o.rd || dmem_o.wr) |-> phase_q != PH_T1)
    else $error("data access in fetch phase");
  branch_dummy_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    t4_redirect_s |=> dummy_slot_s)
    else $error("branch dummy cycle missing");
  branch_target_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    t4_redirect_s |=> imem_rd_o && imem_addr_o == $past(tgt))
    else $error("branch target not fetched");
  skip_flush_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (phase_q == PH_T4 && flush_d) |=> dummy_cycle_o && !exec_valid_q)
    else $error("skip did not flush");
  pcl_page_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (phase_q == PH_T4 && exec_valid_q && opc == `FPP_OP_ST && eff_addr == `FPP_PCL_ADDR)
    |=> pc_q[`FPP_PC_W-1:8] == $past(pc_q[`FPP_PC_W-1:8]))
    else $error("pc low write left page");
  reset_clean_a: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> phase_q == PH_T1 && !exec_valid_q && pc_q == `FPP_PC_RESET)
    else $error("reset state wrong");
endmodule

// ### rtl/fpp_defs.svh
`ifndef FPP_DEFS_SVH
`define FPP_DEFS_SVH
`define FPP_PC_W        11
`define FPP_IW_W        16
`define FPP_PC_RESET    11'h000
`define FPP_PH1         2'h0
`define FPP_PH4         2'h3
`define FPP_PCL_ADDR    8'h02
`define FPP_NOP_WORD    16'h0000
`define FPP_OP_JMP      4'h1
`define FPP_OP_CALL     4'h2
`define FPP_OP_RET      4'h3
`define FPP_OP_ALU      4'h4
`define FPP_OP_ALUM     4'h5
`define FPP_OP_SZ       4'h6
`define FPP_OP_SNZ      4'h7
`define FPP_OP_LDI      4'h8
`define FPP_OP_ST       4'h9
`define FPP_OP_LDM      4'ha
`define FPP_OP_LDIND    4'hb
`define FPP_OP_STIND    4'hc
`define FPP_OP_SETMP    4'hd
`define FPP_STACK_D     4
`endif

// ### rtl/fpp_pkg.sv
package fpp_pkg;
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} fpp_phase_t;
  typedef enum logic [2:0] {AO_ADD, AO_SUB, AO_AND, AO_OR, AO_XOR, AO_RR, AO_INC, AO_DEC} fpp_aluop_t;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpp_dmem_req_t;
  typedef struct packed {
    logic [7:0] res;
    logic       zero;
    logic       carry;
  } fpp_alu_res_t;
endpackage

// ### rtl/fpp_alu.sv
`timescale 1ns/1ns
`include "fpp_defs.svh"
module fpp_alu
  import fpp_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire fpp_aluop_t op_i,
  output fpp_alu_res_t    res_o
);
  logic [8:0] sum;

  always_comb
  begin
    sum = 9'h000;
    case (op_i)
      AO_ADD:  sum = {1'b0, a_i} + {1'b0, b_i};
      AO_SUB:  sum = {1'b0, a_i} - {1'b0, b_i};
      AO_AND:  sum = {1'b0, a_i & b_i};
      AO_OR:   sum = {1'b0, a_i | b_i};
      AO_XOR:  sum = {1'b0, a_i ^ b_i};
      AO_RR:   sum = {a_i[0], a_i[0], a_i[7:1]};
      AO_INC:  sum = {1'b0, b_i} + 9'h001;
      AO_DEC:  sum = {1'b0, b_i} - 9'h001;
      default: sum = 9'h000;
    endcase
  end

  // 8-bit path for arithmetic, logic, rotate, inc/dec and skip tests
  assign res_o.res   = sum[7:0];
  assign res_o.zero  = (sum[7:0] == 8'h00);
  assign res_o.carry = sum[8];
endmodule

// ### tb/fpp_prog_mem_model.sv
`timescale 1ns/1ns
`include "fpp_defs.svh"
module fpp_prog_mem_model
  import fpp_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic [`FPP_PC_W-1:0] addr_i,
  input  wire logic                 rd_i,
  output logic      [`FPP_IW_W-1:0] data_o
);
  logic [`FPP_IW_W-1:0] last_q;

  // fixed test program: loads, store, jump, call/return, pc low write,
  // indirect store/load, alu ops, taken and untaken skips
  function automatic logic [`FPP_IW_W-1:0] word(input logic [`FPP_PC_W-1:0] a);
    case (a)
      11'h000: word = 16'h805a;
      11'h001: word = 16'h9010;
      11'h002: word = 16'h1005;
      11'h003: word = 16'h80ff;
      11'h004: word = 16'h80ee;
      11'h005: word = 16'ha010;
      11'h006: word = 16'h2008;
      11'h007: word = 16'h100a;
      11'h008: word = 16'h8011;
      11'h009: word = 16'h3000;
      11'h00a: word = 16'h800e;
      11'h00b: word = 16'h9002;
      11'h00c: word = 16'h8077;
      11'h00e: word = 16'hd020;
      11'h00f: word = 16'hc000;
      11'h010: word = 16'h4020;
      11'h011: word = 16'h6230;
      11'h012: word = 16'h80ff;
      11'h013: word = 16'h7230;
      11'h014: word = 16'h5620;
      11'h015: word = 16'hb000;
      11'h016: word = 16'h1016;
      default: word = `FPP_NOP_WORD;
    endcase
  endfunction

  always_ff @(posedge sys_clk_i)
  begin
    if (rd_i)
      last_q <= word(addr_i);
  end

  // released bus shows the inverse of the last word, never a stale copy
  assign data_o = rd_i ? word(addr_i) : ~last_q;
endmodule

// ### tb/four_phase_fetch_execute_pipeline_test.sv
`timescale 1ns/1ns
`include "fpp_defs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module four_phase_fetch_execute_pipeline_test
  import fpp_pkg::*;
;
  typedef struct packed {
    logic [10:0] addr;
    logic        dummy;
    logic [7:0]  acc;
  } fpp_row_t;

  logic                 sys_clk_i = 1'b0;
  logic                 sys_rst_i = 1'b1;
  logic [`FPP_IW_W-1:0] imem_data;
  logic [7:0]           dmem_rdata;
  logic [`FPP_PC_W-1:0] imem_addr;
  logic                 imem_rd;
  fpp_dmem_req_t        dmem;
  logic [3:0]           phase;
  logic                 instr_cycle;
  logic                 dummy;
  logic [7:0]           acc;
  logic [7:0]           dmem_q [256] = '{default: 8'h00};
  int                   fail_count = 0;
  int                   samples_checked = 0;
  fpp_row_t             rows [28] = '{
    {11'h000, 1'b0, 8'h00}, {11'h001, 1'b0, 8'h00}, {11'h002, 1'b0, 8'h5a},
    {11'h003, 1'b0, 8'h5a}, {11'h005, 1'b1, 8'h5a}, {11'h006, 1'b0, 8'h5a},
    {11'h007, 1'b0, 8'h5a}, {11'h008, 1'b1, 8'h5a}, {11'h009, 1'b0, 8'h5a},
    {11'h00a, 1'b0, 8'h11}, {11'h007, 1'b1, 8'h11}, {11'h008, 1'b0, 8'h11},
    {11'h00a, 1'b1, 8'h11}, {11'h00b, 1'b0, 8'h11}, {11'h00c, 1'b0, 8'h0e},
    {11'h00e, 1'b1, 8'h0e}, {11'h00f, 1'b0, 8'h0e}, {11'h010, 1'b0, 8'h0e},
    {11'h011, 1'b0, 8'h0e}, {11'h012, 1'b0, 8'h1c}, {11'h013, 1'b1, 8'h1c},
    {11'h014, 1'b0, 8'h1c}, {11'h015, 1'b0, 8'h1c}, {11'h016, 1'b0, 8'h1c},
    {11'h017, 1'b0, 8'h0f}, {11'h016, 1'b1, 8'h0f}, {11'h017, 1'b0, 8'h0f},
    {11'h016, 1'b1, 8'h0f}};

  always #4 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i)
  begin
    if (dmem.wr)
      dmem_q[dmem.addr] <= dmem.wdata;
  end

  assign dmem_rdata = dmem_q[dmem.addr];

  fpp_prog_mem_model prog (
    .sys_clk_i (sys_clk_i),
    .addr_i    (imem_addr),
    .rd_i      (imem_rd),
    .data_o    (imem_data)
  );

  fpp_core dut (
    .sys_clk_i      (sys_clk_i),
    .sys_rst_i      (sys_rst_i),
    .imem_data_i    (imem_data),
    .dmem_rdata_i   (dmem_rdata),
    .imem_addr_o    (imem_addr),
    .imem_rd_o      (imem_rd),
    .dmem_o         (dmem),
    .phase_clocks_o (phase),
    .instr_cycle_o  (instr_cycle),
    .dummy_cycle_o  (dummy),
    .acc_o          (acc)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    for (int k = 0; k < 28; k++)
    begin
      for (int p = 0; p < 4; p++)
      begin
        `CHK("phase", 4'h1 << p, phase)
        `CHK("cycle_end", p == 3, instr_cycle)
        `CHK("fetch_rd", p == 0, imem_rd)
        `CHK("dummy", rows[k].dummy, dummy)
        if (p == 0)
        begin
          `CHK("fetch_addr", rows[k].addr, imem_addr)
          `CHK("acc", rows[k].acc, acc)
        end
        if (k == 2 && p == 3)
        begin
          `CHK("st_wr", 1'b1, dmem.wr)
          `CHK("st_addr", 8'h10, dmem.addr)
          `CHK("st_data", 8'h5a, dmem.wdata)
        end
        if (k == 5 && p == 1)
        begin
          `CHK("ld_rd", 1'b1, dmem.rd)
          `CHK("ld_addr", 8'h10, dmem.addr)
        end
        if (k == 17 && p == 3)
        begin
          `CHK("sti_addr", 8'h20, dmem.addr)
          `CHK("sti_data", 8'h0e, dmem.wdata)
        end
        if (k == 22 && p == 3)
          `CHK("alum_data", 8'h0f, dmem.wdata)
        step();
      end
    end
    // reset in mid cycle, taken while in the second phase
    step();
    sys_rst_i = 1'b1;
    step();
    sys_rst_i = 1'b0;
    `CHK("rst_phase", 4'h1, phase)
    `CHK("rst_addr", 11'h000, imem_addr)
    `CHK("rst_acc", 8'h00, acc)
    `CHK("rst_dummy", 1'b0, dummy)
    repeat (4) step();
    `CHK("rst_next", 11'h001, imem_addr)
    repeat (4) step();
    `CHK("rst_exec", 8'h5a, acc)
    stop_test();
  end

  initial
  begin
    for (int t = 0; t < 2000; t++)
      @(posedge sys_clk_i);
    fail_count++;
    stop_test();
  end
endmodule
